// File: hdl/twzs_pkg.sv
// Constants and types for the table-write and test-skip-zero executor.
// Assumes a core that issues one instruction word per four-phase cycle.
package twzs_pkg;

   // Clock and phase timing
   localparam int unsigned   CLK_PERIOD_NS  = 20;
   localparam int unsigned   PHASES_PER_CYC = 4;
   localparam logic [1:0]    PH_Q1          = 2'h0;
   localparam logic [1:0]    PH_Q2          = 2'h1;
   localparam logic [1:0]    PH_Q3          = 2'h2;
   localparam logic [1:0]    PH_Q4          = 2'h3;

   // Widths
   localparam int unsigned   TPTR_W  = 21;
   localparam int unsigned   HOLD_N  = 8;
   localparam int unsigned   HIDX_W  = 3;
   localparam int unsigned   DADDR_W = 12;
   localparam int unsigned   BANK_W  = 4;

   // Table-write encoding: 0000 0000 0000 11nn
   localparam logic [13:0]   TW_OPC_HI   = 14'h0003;
   // Test-skip-zero encoding: 0110 011a ffff ffff
   localparam logic [6:0]    TST_OPC_HI  = 7'h33;
   localparam int unsigned   TST_A_BIT   = 8;

   // Access bank split and indexed window limit
   localparam logic [7:0]    ACC_SPLIT   = 8'h60;
   localparam logic [7:0]    IDX_LIMIT   = 8'h5f;
   localparam logic [3:0]    ACC_HI_BANK = 4'hf;
   localparam logic [3:0]    ACC_LO_BANK = 4'h0;

   // Reset values
   localparam logic [20:0]   TPTR_RST  = 21'h000000;
   localparam logic [7:0]    HOLD_RST  = 8'hff;
   localparam logic [11:0]   DADDR_RST = 12'h000;

   typedef enum logic [1:0] {
      TW_NONE = 2'h0,
      TW_POST_INC = 2'h1,
      TW_POST_DEC = 2'h2,
      TW_PRE_INC = 2'h3
   } twzs_mode_type;

   typedef enum logic [5:0] {
      ST_DECODE = 6'h01,
      ST_TW1    = 6'h02,
      ST_TW2    = 6'h04,
      ST_TST    = 6'h08,
      ST_SKIP1  = 6'h10,
      ST_SKIP2  = 6'h20
   } twzs_fsm_type;

   typedef struct packed {
      twzs_fsm_type             st;
      logic [1:0]               q;
      logic [TPTR_W-1:0]        tptr;
      twzs_mode_type            mode;
      logic [7:0]               latch;
      logic [HOLD_N-1:0][7:0]   hold;
      logic [HIDX_W-1:0]        hidx;
      logic                     hwe;
      logic [DADDR_W-1:0]       daddr;
      logic                     drd;
      logic                     zero;
      logic                     two;
      logic                     flush;
      logic                     busy;
      logic                     done;
      logic                     stat_we;
   } twzs_state_type;

endpackage

// File: hdl/twzs_exec.sv
// Executor for the table-write tail and the test-skip-if-zero instruction.
// Assumes fetch offers a word at Q1 and stalls while o_busy is high.
`timescale 1ns/1ps
`default_nettype none

module twzs_exec
   import twzs_pkg::*;
(
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_instr_valid,
   input  wire logic [15:0]              i_instr_word,
   input  wire logic [7:0]               i_table_latch,
   input  wire logic [7:0]               i_operand_data,
   input  wire logic [BANK_W-1:0]        i_bank_select_register,
   input  wire logic [DADDR_W-1:0]       i_index_base,
   input  wire logic                     i_ext_set_en,
   input  wire logic                     i_next_two_word,
   input  wire logic                     i_tptr_load,
   input  wire logic [TPTR_W-1:0]        i_tptr_value,
   output logic [TPTR_W-1:0]             o_table_pointer,
   output logic                          o_byte_high,
   output logic [HOLD_N*8-1:0]           o_holding,
   output logic                          o_hold_we,
   output logic [HIDX_W-1:0]             o_hold_index,
   output logic [DADDR_W-1:0]            o_data_addr,
   output logic                          o_data_rd,
   output logic                          o_flush,
   output logic                          o_busy,
   output logic                          o_done,
   output logic                          o_status_we,
   output logic [1:0]                    o_phase
);

   function automatic logic is_tw(input logic [15:0] w);
      return w[15:2] == TW_OPC_HI;
   endfunction

   function automatic logic is_tst(input logic [15:0] w);
      return w[15:9] == TST_OPC_HI;
   endfunction

   twzs_state_type st_r;
   twzs_state_type st_nxt;
   logic           take;
   logic [7:0]     f_fld;
   logic           a_bit;
   logic [TPTR_W-1:0] tptr_bit;

   assign take  = (st_r.st == ST_DECODE) && (st_r.q == PH_Q1) &&
                  i_instr_valid;
   assign f_fld = i_instr_word[7:0];
   assign a_bit = i_instr_word[TST_A_BIT];
   assign tptr_bit = {{(TPTR_W-1){1'b0}}, 1'b1};

   always_comb begin
      st_nxt = st_r;
      st_nxt.q = st_r.q + 2'h1;
      st_nxt.hwe = 1'b0;
      st_nxt.drd = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.stat_we = 1'b0;
      case (st_r.st)
         ST_DECODE: begin
            st_nxt.busy = 1'b0;
            if (i_tptr_load) begin
               st_nxt.tptr = i_tptr_value;
            end
            if (take && is_tw(i_instr_word)) begin
               st_nxt.mode = twzs_mode_type'(i_instr_word[1:0]);
               st_nxt.st = ST_TW1;
               st_nxt.busy = 1'b1;
            end else if (take && is_tst(i_instr_word)) begin
               st_nxt.st = ST_TST;
               st_nxt.drd = 1'b1;
               if (a_bit) begin
                  st_nxt.daddr = {i_bank_select_register, f_fld};
               end else if (i_ext_set_en && (f_fld <= IDX_LIMIT)) begin
                  st_nxt.daddr = DADDR_W'(i_index_base + {4'h0, f_fld});
               end else if (f_fld < ACC_SPLIT) begin
                  st_nxt.daddr = {ACC_LO_BANK, f_fld};
               end else begin
                  st_nxt.daddr = {ACC_HI_BANK, f_fld};
               end
            end else if (take) begin
               st_nxt.done = 1'b1;
            end
         end
         ST_TW1: begin
            if (st_r.q == PH_Q4) begin
               if (st_r.mode == TW_PRE_INC) begin
                  st_nxt.tptr = TPTR_W'(st_r.tptr + tptr_bit);
               end
               st_nxt.st = ST_TW2;
            end
         end
         ST_TW2: begin
            // latch read in second cycle Q2
            if (st_r.q == PH_Q2) begin
               st_nxt.latch = i_table_latch;
            end
            if (st_r.q == PH_Q4) begin
               // low pointer bits pick holding register
               st_nxt.hold[st_r.tptr[HIDX_W-1:0]] = st_r.latch;
               st_nxt.hidx = st_r.tptr[HIDX_W-1:0];
               st_nxt.hwe = 1'b1;
               if (st_r.mode == TW_POST_INC) begin
                  st_nxt.tptr = TPTR_W'(st_r.tptr + tptr_bit);
               end else if (st_r.mode == TW_POST_DEC) begin
                  st_nxt.tptr = TPTR_W'(st_r.tptr - tptr_bit);
               end
               st_nxt.st = ST_DECODE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end
         end
         ST_TST: begin
            if (st_r.q == PH_Q2) begin
               st_nxt.zero = (i_operand_data == 8'h00);
            end
            if (st_r.q == PH_Q4) begin
               st_nxt.two = i_next_two_word;
               if (st_r.zero) begin
                  st_nxt.flush = 1'b1;
                  st_nxt.busy = 1'b1;
                  st_nxt.st = ST_SKIP1;
               end else begin
                  st_nxt.st = ST_DECODE;
                  st_nxt.done = 1'b1;
               end
            end
         end
         ST_SKIP1: begin
            if (st_r.q == PH_Q4) begin
               if (st_r.two) begin
                  st_nxt.flush = 1'b1;
                  st_nxt.st = ST_SKIP2;
               end else begin
                  st_nxt.st = ST_DECODE;
                  st_nxt.busy = 1'b0;
                  st_nxt.done = 1'b1;
               end
            end
         end
         ST_SKIP2: begin
            if (st_r.q == PH_Q4) begin
               st_nxt.st = ST_DECODE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end
         end
         default: begin
            st_nxt.st = ST_DECODE;
         end
      endcase
   end

   // Holding bytes reset erased so an early program shows untouched lanes
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_r <= '0;
         st_r.st <= ST_DECODE;
         st_r.tptr <= TPTR_RST;
         st_r.hold <= {HOLD_N{HOLD_RST}};
         st_r.daddr <= DADDR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_table_pointer = st_r.tptr;
   assign o_byte_high = st_r.tptr[0];
   assign o_holding = st_r.hold;
   assign o_hold_we = st_r.hwe;
   assign o_hold_index = st_r.hidx;
   assign o_data_addr = st_r.daddr;
   assign o_data_rd = st_r.drd;
   assign o_flush = st_r.flush;
   assign o_busy = st_r.busy;
   assign o_done = st_r.done;
   assign o_status_we = st_r.stat_we;
   assign o_phase = st_r.q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   sequence tw_start;
      take && is_tw(i_instr_word);
   endsequence

   sequence tst_start;
      take && is_tst(i_instr_word);
   endsequence

   sequence skip_decided;
      (st_r.st == ST_TST) && (st_r.q == PH_Q4) && st_r.zero;
   endsequence

   // Busy spans the seven clocks after the take; write and done land together
   chk_tw_two_cycles: assert property (
      tw_start |=> o_busy [*7] ##1 (o_hold_we && o_done && !o_busy))
      else $error("table write did not finish in two cycles");

   chk_tw_post_inc: assert property (
      o_hold_we && (st_r.mode == TW_POST_INC) |->
      o_table_pointer == TPTR_W'($past(o_table_pointer) + 21'h000001))
      else $error("post increment wrong");

   chk_tw_no_change: assert property (
      (st_r.st == ST_TW2) && (st_r.mode == TW_NONE) |=>
      $stable(o_table_pointer))
      else $error("pointer moved in no-change mode");

   chk_tw_post_dec: assert property (
      o_hold_we && (st_r.mode == TW_POST_DEC) |->
      o_table_pointer == TPTR_W'($past(o_table_pointer) - 21'h000001))
      else $error("post decrement wrong");

   // Pointer moved four clocks before the write, and the write used it
   chk_tw_pre_inc: assert property (
      o_hold_we && (st_r.mode == TW_PRE_INC) |->
      (o_table_pointer == TPTR_W'($past(o_table_pointer, 5) + 21'h000001))
      && (o_hold_index == o_table_pointer[HIDX_W-1:0]))
      else $error("pre increment wrong");

   chk_hold_index_data: assert property (
      o_hold_we |-> o_holding[8*o_hold_index +: 8] == $past(i_table_latch, 3))
      else $error("holding register not written with latch");

   chk_skip_flush: assert property (
      skip_decided |=> o_flush && (st_r.st == ST_SKIP1))
      else $error("zero operand did not flush");

   chk_skip_two_word: assert property (
      skip_decided ##1 st_r.two |-> ##4 o_flush ##4 o_done)
      else $error("two-word skip not three cycles");

   chk_bank_addr: assert property (
      tst_start and a_bit |=>
      o_data_addr == {$past(i_bank_select_register), $past(f_fld)})
      else $error("bank select address wrong");

   chk_indexed_addr: assert property (
      tst_start and (!a_bit && i_ext_set_en && (f_fld <= IDX_LIMIT)) |=>
      o_data_addr == DADDR_W'($past(i_index_base) + {4'h0, $past(f_fld)}))
      else $error("indexed literal offset address wrong");

   chk_status_quiet: assert property (
      tst_start |-> !o_status_we [*8])
      else $error("status written by test-skip");

endmodule // twzs_exec

`default_nettype wire

// File: test/twzs_exec_tb.sv
// Self-checking bench for the table-write and test-skip-zero executor.
// Assumes the executor alone runs on i_ref_clk; inputs move 1 ns after edges.
`timescale 1ns/1ps
`default_nettype none
module twzs_exec_tb;
   import twzs_pkg::*;
   logic        clk, rst, vld, ext, two, ld, bh, hwe, drd, fl, busy;
   logic        done, swe, bz, sw;
   logic [15:0] word;
   logic [7:0]  lat, opd;
   logic [3:0]  bank_select_register;
   logic [11:0] base, dad, ra;
   logic [20:0] tval, ptr;
   logic [63:0] hold, he;
   logic [2:0]  hidx, hs;
   logic [1:0]  ph;
   logic [31:0] r;
   int          num_errors, n_checks, seed, cd, cw, cr, nf, f1, i;

   twzs_exec dut_u (
      .i_ref_clk(clk), .i_reset(rst), .i_instr_valid(vld),
      .i_instr_word(word), .i_table_latch(lat), .i_operand_data(opd),
      .i_bank_select_register(bank_select_register), .i_index_base(base),
      .i_ext_set_en(ext), .i_next_two_word(two), .i_tptr_load(ld),
      .i_tptr_value(tval), .o_table_pointer(ptr), .o_byte_high(bh),
      .o_holding(hold), .o_hold_we(hwe), .o_hold_index(hidx),
      .o_data_addr(dad), .o_data_rd(drd), .o_flush(fl), .o_busy(busy),
      .o_done(done), .o_status_we(swe), .o_phase(ph));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk_val(string nm, logic [63:0] e, logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_cyc(string nm, int e, int g);
      n_checks++;
      if (g != e) begin
         num_errors++;
         $display("ERROR %s exp %0d got %0d", nm, e, g);
      end
   endtask

   // Offer one word at the next phase 0, then log pulses for 13 clocks
   task automatic run(logic [15:0] w);
      int c;
      cd = 0; cw = 0; cr = 0; nf = 0; f1 = 0; sw = 1'b0;
      do begin
         @(posedge clk); #1;
      end while (ph !== 2'h0);
      vld = 1'b1;
      word = w;
      @(posedge clk); #1;
      vld = 1'b0;
      word = ~w;
      for (c = 1; c < 14; c++) begin
         if (c == 1) bz = busy;
         if (done === 1'b1 && cd == 0) cd = c;
         if (hwe === 1'b1) begin
            cw = c;
            hs = hidx;
         end
         if (drd === 1'b1) begin
            cr = c;
            ra = dad;
         end
         if (fl === 1'b1) begin
            nf++;
            if (f1 == 0) f1 = c;
         end
         if (swe !== 1'b0) sw = 1'b1;
         @(posedge clk); #1;
      end
   endtask

   task automatic tw(logic [1:0] m, logic [20:0] p, logic [7:0] l);
      logic [20:0] q;
      ld = 1'b1;
      tval = p;
      @(posedge clk); #1;
      ld = 1'b0;
      chk_val("ptr_load", p, ptr);
      lat = l;
      q = (m == 2'h3) ? p + 21'h1 : p;
      he[8*q[2:0] +: 8] = l;
      run({TW_OPC_HI, m});
      chk_cyc("tw_done", 8, cd);
      chk_cyc("tw_we", 8, cw);
      chk_val("tw_busy", 1, bz);
      chk_val("hold_idx", q[2:0], hs);
      chk_val("holding", he, hold);
      q = (m == 2'h0) ? p : (m == 2'h2) ? p - 21'h1 : p + 21'h1;
      chk_val("tptr", q, ptr);
      chk_val("byte_high", q[0], bh);
   endtask

   task automatic ts(logic a, logic [7:0] f, logic [7:0] d, logic x, logic t);
      logic [11:0] ea;
      opd = d;
      ext = x;
      two = t;
      run({TST_OPC_HI, a, f});
      if (a)
         ea = {bank_select_register, f};
      else if (x && f <= IDX_LIMIT)
         ea = base + {4'h0, f};
      else
         ea = {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
      chk_val("data_addr", ea, ra);
      chk_cyc("rd_cycle", 1, cr);
      chk_cyc("tst_done", (d != 0) ? 4 : t ? 12 : 8, cd);
      chk_cyc("flushes", (d != 0) ? 0 : t ? 2 : 1, nf);
      chk_cyc("flush_at", (d != 0) ? 0 : 4, f1);
      chk_val("status_we", 0, sw);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("ERROR watchdog expired");
      summarize();
   end

   initial begin
      seed = 32'h6bf4cf47;
      rst = 1'b1; vld = 1'b0; ext = 1'b0; two = 1'b0; ld = 1'b0;
      word = 16'h0000; lat = 8'h00; opd = 8'h00; bank_select_register = 4'h0;
      base = 12'h000; tval = 21'h000000; he = {8{8'hff}};
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      chk_val("rst_ptr", 0, ptr);
      chk_val("rst_hold", he, hold);
      chk_val("rst_phase", 0, ph);
      // Corner cases, with the pointer incrementing past the top and decrementing past 0
      tw(2'h1, 21'h00a356, 8'h55);
      tw(2'h3, 21'h01389a, 8'h34);
      tw(2'h1, 21'h1fffff, 8'ha5);
      tw(2'h2, 21'h000000, 8'h3c);
      tw(2'h0, 21'h000007, 8'h81);
      tw(2'h3, 21'h000007, 8'h7e);
      // A word that is neither instruction must finish at once, no write
      run(16'h0000);
      chk_cyc("nop_done", 1, cd);
      chk_cyc("nop_we", 0, cw);
      $display("test table_write corners done");
      for (i = 0; i < 20; i++) begin
         r = $random(seed);
         tw(r[1:0], r[22:2], r[30:23]);
      end
      $display("test table_write random done");
      // Base near the top makes the indexed sum wrap
      bank_select_register = 4'ha;
      base = 12'hff0;
      for (i = 0; i < 16; i++) begin
         ts(i[0], i[2] ? 8'h5f : 8'h60, i[3] ? 8'h00 : 8'h80, i[1],
            i[0] ^ i[1]);
      end
      $display("test skip_zero corners done");
      for (i = 0; i < 30; i++) begin
         r = $random(seed);
         bank_select_register = r[23:20];
         base = r[31:20];
         ts(r[0], r[8:1], r[9] ? 8'h00 : r[17:10], r[18], r[19]);
      end
      $display("test skip_zero random done");
      summarize();
   end
endmodule // twzs_exec_tb
`default_nettype wire
